// ### hdl/sek_pkg.sv
// sek_pkg: shared constants for the serial eeprom sequencer and its host
package sek_pkg;
    // ************************************************************
    // opcodes, msb first
    // ************************************************************
    localparam logic [7:0] OP_SET_WEL  = 8'h06; // set_write_latch_cmd
    localparam logic [7:0] OP_CLR_WEL  = 8'h04; // clear_write_latch_cmd
    localparam logic [7:0] OP_FLAG_SET = 8'h00; // flag_set_cmd
    localparam logic [7:0] OP_STAT_RD  = 8'h05; // status_read_cmd
    localparam logic [7:0] OP_STAT_WR  = 8'h01; // status_write_cmd
    localparam logic [7:0] OP_ARR_RD   = 8'h03;
    localparam logic [7:0] OP_ARR_WR   = 8'h02;

    // ************************************************************
    // array and status layout
    // ************************************************************
    localparam int ARRAY_AW = 12;
    localparam int PAGE_AW  = 5;
    localparam int PAGE_LEN = 32;
    localparam int ARRAY_LEN = 4096;
    localparam logic [7:0] MEM_RST     = 8'hff;
    localparam int STAT_BUSY_BIT = 0;  // write_busy_bit
    localparam int STAT_WEL_BIT  = 1;  // write_enable_latch_bit
    localparam int STAT_FLAG_BIT = 6;  // user_flag_bit
    localparam logic [5:0] STAT_NV_RST = 6'h0c; // status bits 7..2

    // ************************************************************
    // timing
    // ************************************************************
    localparam int MCLK_NS       = 10;
    localparam int WRITE_CYC_NS  = 10000000;
    localparam int WC_CYC        = WRITE_CYC_NS / MCLK_NS;
    localparam int SCK_HALF_NS   = 250;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + MCLK_NS - 1) / MCLK_NS;

    // ************************************************************
    // host register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_DIV  = 8'h08;
    localparam int CTRL_SEL_BIT  = 0;
    localparam int CTRL_BUSY_BIT = 1;
endpackage : sek_pkg

// ### hdl/sek_spi_if.sv
// sek_spi_if: four-wire serial link between host and eeprom device
`timescale 1ns/100ps
`default_nettype none
interface sek_spi_if;
    logic cs_n;   // chip select, low active
    logic sck;    // serial clock, host made
    logic si;     // host to device data
    logic so;     // device to host data
    logic so_oe;  // device drives so while high

    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so,
                  input so_oe);
endinterface : sek_spi_if
`default_nettype wire

// ### hdl/sek_sync.sv
// sek_sync: two flip-flop synchroniser for link inputs
`timescale 1ns/100ps
`default_nettype none
module sek_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= RST;
            dout   <= RST;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : sek_sync
`default_nettype wire

// ### hdl/sek_dev.sv
// sek_dev: serial eeprom command sequencer, device end of the link
`timescale 1ns/100ps
`default_nettype none
module sek_dev
    import sek_pkg::*;
#(
    parameter int WRITE_CYCLES = WC_CYC
) (
    input  wire logic mclk,
    input  wire logic reset,
    sek_spi_if.dev    spi
);
    // ************************************************************
    // types and state
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_OPC  = 4'h1,
        ST_ADDR = 4'h2,
        ST_RDAT = 4'h3,
        ST_SRD  = 4'h4,
        ST_WDAT = 4'h5,
        ST_SWR  = 4'h6,
        ST_DONE = 4'h7,
        ST_IGN  = 4'h8
    } sek_st_e;

    localparam logic [19:0] WC_LAST = 20'(WRITE_CYCLES - 1);

    sek_st_e                state_q;
    logic [3:0]             bit_q;
    logic [14:0]            sh_q;
    logic [7:0]             opc_q;
    logic [ARRAY_AW-1:0]    addr_q;
    logic [PAGE_AW-1:0]     woff_q;
    logic [PAGE_LEN-1:0]    pval_q;
    logic [7:0]             pbuf_q [PAGE_LEN];
    logic                   byte_ok_q;
    logic [7:0]             sdat_q;
    logic [7:0]             out_q;
    logic [2:0]             obit_q;
    logic                   so_q;
    logic                   so_oe_q;
    logic [7:0]             mem_q [ARRAY_LEN];
    logic                   wel_q;
    logic                   flag_q;
    logic [5:0]             nv_q;
    logic                   busy_q;
    logic [19:0]            bcnt_q;
    logic                   cs_p_q;
    logic                   sck_p_q;

    // ************************************************************
    // link sampling and edge detection
    // ************************************************************
    logic [2:0] lnk_s;
    logic       cs_s;
    logic       sck_s;
    logic       si_s;

    sek_sync #(
        .W   (3),
        .RST (3'h0)
    ) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   ({spi.cs_n, spi.sck, spi.si}),
        .dout  (lnk_s)
    );

    assign cs_s  = lnk_s[2];
    assign sck_s = lnk_s[1];
    assign si_s  = lnk_s[0];

    // previous levels; synced select and cs_p both reset low, so a select
    // held low across reset never looks like a fall
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cs_p_q  <= 1'b0;
            sck_p_q <= 1'b0;
        end else begin
            cs_p_q  <= cs_s;
            sck_p_q <= sck_s;
        end
    end

    // ************************************************************
    // decode
    // ************************************************************
    wire        cs_fall   = cs_p_q & ~cs_s;
    wire        cs_rise   = ~cs_p_q & cs_s;
    wire        sck_rise  = ~cs_s & sck_s & ~sck_p_q;
    wire        sck_fall  = ~cs_s & ~sck_s & sck_p_q;
    wire [15:0] in16      = {sh_q, si_s};
    wire [7:0]  in8       = in16[7:0];
    wire        last8     = (bit_q == 4'h7);
    wire        last16    = (bit_q == 4'hf);
    wire [7:0]  status    = {nv_q[5], flag_q, nv_q[3:0],
                             wel_q, busy_q};
    wire        wr_ok     = wel_q & ~busy_q;
    wire        commit_ar = cs_rise & (state_q == ST_WDAT)
                            & byte_ok_q;
    wire        do_cmd    = cs_rise & (state_q == ST_DONE);
    wire        commit_sw = do_cmd & (opc_q == OP_STAT_WR);
    wire        start_wr  = commit_ar | commit_sw;
    wire [7:0]  rd_byte   = (state_q == ST_SRD) ? status
                                                : mem_q[addr_q];

    // opcode dispatch after eight bits; busy lets only status reads in
    sek_st_e opc_next;
    always_comb begin
        opc_next = ST_IGN;
        if (in8 == OP_STAT_RD) begin
            opc_next = ST_SRD;
        end else if (!busy_q) begin
            case (in8)
                OP_ARR_RD:  opc_next = ST_ADDR;
                OP_ARR_WR:  opc_next = wr_ok ? ST_ADDR : ST_IGN;
                OP_STAT_WR: opc_next = wr_ok ? ST_SWR : ST_IGN;
                OP_SET_WEL: opc_next = ST_DONE;
                OP_CLR_WEL: opc_next = ST_DONE;
                OP_FLAG_SET: opc_next = ST_DONE;
                default:    opc_next = ST_IGN;
            endcase
        end
    end

    // ************************************************************
    // link sequencer
    // ************************************************************
    // shifts on sck rise, drives so on sck fall
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 15'h0000;
            opc_q     <= 8'h00;
            addr_q    <= '0;
            woff_q    <= '0;
            pval_q    <= '0;
            byte_ok_q <= 1'b0;
            sdat_q    <= 8'h00;
            out_q     <= 8'h00;
            obit_q    <= 3'h0;
            so_q      <= 1'b0;
            so_oe_q   <= 1'b0;
        end else if (cs_s) begin
            state_q <= ST_IDLE;
            so_oe_q <= 1'b0;
        end else if (cs_fall) begin
            state_q   <= ST_OPC;
            bit_q     <= 4'h0;
            obit_q    <= 3'h0;
            byte_ok_q <= 1'b0;
        end else if (sck_rise) begin
            sh_q  <= in16[14:0];
            bit_q <= bit_q + 4'h1;
            case (state_q)
                ST_OPC: if (last8) begin
                    opc_q   <= in8;
                    state_q <= opc_next;
                    bit_q   <= 4'h0;
                end
                ST_ADDR: if (last16) begin
                    addr_q  <= in16[ARRAY_AW-1:0];
                    woff_q  <= in16[PAGE_AW-1:0];
                    pval_q  <= '0;
                    bit_q   <= 4'h0;
                    state_q <= (opc_q == OP_ARR_RD) ? ST_RDAT : ST_WDAT;
                end
                ST_WDAT: begin
                    byte_ok_q <= last8;
                    if (last8) begin
                        pval_q[woff_q] <= 1'b1;
                        woff_q <= woff_q + PAGE_AW'(1);
                        bit_q  <= 4'h0;
                    end
                end
                ST_SWR: if (last8) begin
                    sdat_q  <= in8;
                    state_q <= ST_DONE;
                end
                ST_DONE: state_q <= ST_IGN;
                default: state_q <= state_q;
            endcase
        end else if (sck_fall) begin
            if (state_q == ST_RDAT || state_q == ST_SRD) begin
                so_oe_q <= 1'b1;
                obit_q  <= obit_q + 3'h1;
                if (obit_q == 3'h0) begin
                    so_q  <= rd_byte[7];
                    out_q <= {rd_byte[6:0], 1'b0};
                    if (state_q == ST_RDAT) begin
                        addr_q <= addr_q + ARRAY_AW'(1);
                    end
                end else begin
                    so_q  <= out_q[7];
                    out_q <= {out_q[6:0], 1'b0};
                end
            end
        end
    end

    // page buffer loads the byte that just completed
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < PAGE_LEN; i++) begin
                pbuf_q[i] <= 8'h00;
            end
        end else if (sck_rise && state_q == ST_WDAT && last8) begin
            pbuf_q[woff_q] <= in8;
        end
    end

    // ************************************************************
    // array storage
    // ************************************************************
    // only loaded bytes of the page reach the array, on a valid commit
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < ARRAY_LEN; i++) begin
                mem_q[i] <= MEM_RST;
            end
        end else if (commit_ar) begin
            for (int i = 0; i < PAGE_LEN; i++) begin
                if (pval_q[i]) begin
                    mem_q[{addr_q[ARRAY_AW-1:PAGE_AW],
                           PAGE_AW'(i)}] <= pbuf_q[i];
                end
            end
        end
    end

    // ************************************************************
    // status, latch and write timer
    // ************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wel_q  <= 1'b0;
            flag_q <= 1'b0;
            nv_q   <= STAT_NV_RST;
            busy_q <= 1'b0;
            bcnt_q <= 20'h00000;
        end else begin
            if (start_wr) begin
                busy_q <= 1'b1;
                bcnt_q <= WC_LAST;
            end else if (busy_q) begin
                if (bcnt_q == 20'h00000) begin
                    busy_q <= 1'b0;
                    wel_q  <= 1'b0;
                end else begin
                    bcnt_q <= bcnt_q - 20'h00001;
                end
            end
            if (do_cmd && opc_q == OP_SET_WEL) begin
                wel_q <= 1'b1;
            end
            if (do_cmd && opc_q == OP_CLR_WEL) begin
                wel_q  <= 1'b0;
                flag_q <= 1'b0;
            end
            if (do_cmd && opc_q == OP_FLAG_SET) begin
                flag_q <= 1'b1;
            end
            if (commit_sw) begin
                nv_q   <= sdat_q[7:2];
                flag_q <= sdat_q[STAT_FLAG_BIT];
            end
        end
    end

    // ************************************************************
    // link outputs
    // ************************************************************
    assign spi.so    = so_q;
    assign spi.so_oe = so_oe_q;
endmodule : sek_dev
`default_nettype wire

// ### hdl/sek_host.sv
// sek_host: register-driven spi byte engine, host end of the link
`timescale 1ns/100ps
`default_nettype none
module sek_host
    import sek_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    sek_spi_if.host         spi
);
    // ************************************************************
    // state
    // ************************************************************
    logic       cs_n_q;
    logic       sck_q;
    logic       si_q;
    logic       busy_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [3:0] nbit_q;
    logic [7:0] div_q;
    logic [7:0] tmr_q;
    logic       so_s;

    // ************************************************************
    // so sampling, released line reads high
    // ************************************************************
    sek_sync #(
        .W   (1),
        .RST (1'b1)
    ) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   (spi.so_oe ? spi.so : 1'b1),
        .dout  (so_s)
    );

    // ************************************************************
    // decode
    // ************************************************************
    wire wr_ctrl = wr & (addr == REG_CTRL);
    wire wr_data = wr & (addr == REG_DATA) & ~cs_n_q & ~busy_q;
    wire wr_div  = wr & (addr == REG_DIV);
    wire tick    = busy_q & (tmr_q == 8'h00);
    wire [7:0] rd_mux = (addr == REG_CTRL) ? {6'h00, busy_q, ~cs_n_q} :
                        (addr == REG_DATA) ? rx_q :
                        (addr == REG_DIV)  ? div_q : 8'h00;

    // ************************************************************
    // register port
    // ************************************************************
    // select changes only between bytes, so it rises on a bit-0 boundary
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cs_n_q <= 1'b1;
            div_q  <= 8'(SCK_HALF_CYC - 1);
            rdata  <= 8'h00;
        end else begin
            if (wr_ctrl && !busy_q) begin
                cs_n_q <= ~wdata[CTRL_SEL_BIT];
            end
            if (wr_div) begin
                div_q <= wdata;
            end
            rdata <= rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // byte engine, mode 0: si set on fall, so taken on rise
    // ************************************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sck_q  <= 1'b0;
            si_q   <= 1'b0;
            busy_q <= 1'b0;
            tx_q   <= 8'h00;
            rx_q   <= 8'h00;
            nbit_q <= 4'h0;
            tmr_q  <= 8'h00;
        end else if (wr_data) begin
            busy_q <= 1'b1;
            si_q   <= wdata[7];
            tx_q   <= {wdata[6:0], 1'b0};
            nbit_q <= 4'h0;
            tmr_q  <= div_q;                                 // lead time
        end else if (busy_q) begin
            tmr_q <= tick ? div_q : tmr_q - 8'h01;
            if (tick && !sck_q) begin
                sck_q  <= 1'b1;
                rx_q   <= {rx_q[6:0], so_s};
                nbit_q <= nbit_q + 4'h1;
            end else if (tick) begin
                sck_q <= 1'b0;
                if (nbit_q == 4'h8) begin
                    busy_q <= 1'b0;
                end else begin
                    si_q <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

    // ************************************************************
    // link outputs
    // ************************************************************
    assign spi.cs_n = cs_n_q;
    assign spi.sck  = sck_q;
    assign spi.si   = si_q;
endmodule : sek_host
`default_nettype wire

// ### tb/sek_checker.sv
// sek_checker: link timing and framing assertions
`timescale 1ns/100ps
`default_nettype none
module sek_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic       sck_q;
    logic       sel_seen_q;
    logic [7:0] rise_cnt_q;
    wire logic  sck_rise = sck & ~sck_q;

    // count sck rises in the frame, note the first select
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sck_q      <= 1'b0;
            sel_seen_q <= 1'b0;
            rise_cnt_q <= 8'h00;
        end else begin
            sck_q      <= sck;
            sel_seen_q <= sel_seen_q | ~cs_n;
            rise_cnt_q <= cs_n ? 8'h00 : rise_cnt_q + {7'h00, sck_rise};
        end
    end

    // ****************************************
    // link assertions
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence deselect_s;
        $rose(cs_n) ##1 cs_n [*2];
    endsequence

    so_start_a: assert property ($rose(so_oe) |->
        !cs_n && (rise_cnt_q == 8'h08 || rise_cnt_q == 8'h18))
        else $error("so enabled at wrong bit count");
    so_release_a: assert property (deselect_s |-> ##[0:2] !so_oe)
        else $error("so still driven after deselect");
    so_quiet_a: assert property (!sel_seen_q |-> !so_oe)
        else $error("so driven before first select");
    so_fall_a: assert property (so_oe && $changed(so) |-> !sck)
        else $error("so changed while sck high");
    so_hold_a: assert property ($fell(sck) && so_oe |->
        $stable(so) [*2])
        else $error("so changed too soon after sck fall");
    si_hold_a: assert property ($rose(sck) |->
        (sck && !cs_n && $stable(si)) [*8])
        else $error("si or sck high phase broken");
    si_edge_a: assert property ($changed(si) |-> !sck)
        else $error("si changed while sck high");
    sck_idle_a: assert property (cs_n |-> !sck)
        else $error("sck high while deselected");
endmodule : sek_checker
`default_nettype wire

// ### tb/tb.sv
// tb: host and device joined over the link, driven by host registers
`timescale 1ns/100ps
`default_nettype none
module tb
    import sek_pkg::*;
;
    logic       mclk       = 1'b0;
    logic       reset      = 1'b1;
    logic [7:0] addr       = 8'h00;
    logic [7:0] wdata      = 8'h00;
    logic       wr         = 1'b0;
    logic       rd         = 1'b0;
    logic [7:0] rdata;
    logic [7:0] rx;
    int         fail_count = 0;
    int         tests_run  = 0;
    logic [7:0] ops [4]    = '{OP_CLR_WEL, OP_FLAG_SET, OP_SET_WEL,
                               OP_CLR_WEL};
    logic [7:0] sts [4]    = '{8'h30, 8'h70, 8'h72, 8'h30};

    sek_spi_if spi ();
    sek_host sek_host_inst (.mclk(mclk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .spi(spi));
    sek_dev #(.WRITE_CYCLES(2000)) sek_dev_inst (.mclk(mclk), .reset(reset),
        .spi(spi));
    sek_checker sek_checker_inst (.mclk(mclk), .reset(reset),
        .cs_n(spi.cs_n), .sck(spi.sck), .si(spi.si), .so(spi.so),
        .so_oe(spi.so_oe));

    // free running clock
    always #(MCLK_NS / 2) mclk = ~mclk;

    // ****************************************
    // register and link tasks
    // ****************************************
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask : rreg

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic sel(input logic v);
        wreg(REG_CTRL, {7'h00, v});
        if (!v) repeat (50) @(posedge mclk);
    endtask : sel

    task automatic tx(input logic [7:0] b);
        logic [7:0] s;
        s = 8'h02;
        wreg(REG_DATA, b);
        for (int i = 0; i < 400 && s[CTRL_BUSY_BIT]; i++) rreg(REG_CTRL, s);
        chk("byte done", 8'h01, s);
        rreg(REG_DATA, rx);
    endtask : tx

    task automatic send(input logic [7:0] q [$]);
        sel(1'b1);
        foreach (q[i]) tx(q[i]);
        sel(1'b0);
    endtask : send

    task automatic rstat();
        send('{OP_STAT_RD, 8'h00});
    endtask : rstat

    task automatic wait_idle();
        rx = 8'h01;
        for (int i = 0; i < 20 && rx[STAT_BUSY_BIT]; i++) rstat();
    endtask : wait_idle

    task automatic rdseq(input logic [15:0] a, input logic [7:0] e [$]);
        sel(1'b1);
        tx(OP_ARR_RD);
        tx(a[15:8]);
        tx(a[7:0]);
        foreach (e[i]) begin
            tx(8'h00);
            chk("array byte", e[i], rx);
        end
        sel(1'b0);
    endtask : rdseq

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // watchdog against a hung link, about three times the expected run
    initial begin
        #500000;
        fail_count++;
        finish_test();
    end

    // main sequence
    initial begin
        logic [7:0] v;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rreg(REG_CTRL, v);
        chk("ctrl", 8'h00, v);
        rreg(REG_DIV, v);
        chk("div reset", 8'h18, v);
        rreg(8'h0c, v);
        chk("unmapped", 8'h00, v);
        wreg(REG_DIV, 8'h07);
        rreg(REG_DIV, v);
        chk("div", 8'h07, v);
        rstat();
        chk("status reset", {STAT_NV_RST, 2'b00}, rx);
        $display("test reset done");
        send('{OP_ARR_WR, 8'h00, 8'h1e, 8'ha5});
        rdseq(16'h001e, '{8'hff});
        send('{OP_SET_WEL, OP_ARR_WR, 8'h00, 8'h1e, 8'ha5});
        rstat();
        chk("status latch", 8'h30, rx);
        rdseq(16'h001e, '{8'hff});
        $display("test refused writes done");
        send('{OP_SET_WEL});
        rstat();
        chk("status latch", 8'h32, rx);
        send('{OP_ARR_WR, 8'h00, 8'h1e});
        rdseq(16'h001e, '{8'hff});
        $display("test aborted write done");
        send('{OP_ARR_WR, 8'h00, 8'h1e, 8'h11, 8'h22, 8'h33, 8'h44});
        wait_idle();
        rstat();
        chk("status after write", 8'h30, rx);
        rdseq(16'h0ffe, '{8'hff, 8'hff, 8'h33, 8'h44, 8'hff});
        rdseq(16'h001d, '{8'hff, 8'h11, 8'h22, 8'hff});
        $display("test page write done");
        send('{OP_SET_WEL});
        send('{OP_STAT_WR, 8'h70});
        rstat();
        chk("status busy", 8'h73, rx);
        send('{OP_CLR_WEL});
        rstat();
        chk("busy refuses op", 8'h73, rx);
        wait_idle();
        rstat();
        chk("status written", 8'h70, rx);
        $display("test status write done");
        foreach (ops[i]) begin
            send('{ops[i]});
            rstat();
            chk("status op", sts[i], rx);
        end
        $display("test opcodes done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
